//--- bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        stop_recover = 1'b0, retrace = 1'b0, on_primary = 1'b0;
  logic        gen_line = 1'b0, in_line = 1'b0, seen_wd, seen_stop, seen_aux;
  logic [3:0]  result = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rnd = 32'hda02_4c79, d;
  logic [32:0] e, exp_q[$];
  wire  [31:0] prdata;
  wire  [11:0] std_cfg;
  wire  [2:0]  conv_in;
  wire  [1:0]  conv_rate;
  wire         pready, pslverr, clamp_v, clamp_a, osc_en, fast_sel, wd_rst, stop_p;
  wire         pin_oe, line_out, line_int, frame_out, frame_int;
  int          fail_count = 0, compares = 0, cycles = 0, clamp_at, clamp_lo;
  // Short watchdog period keeps the run brief
  tv_ctrl_bank1 #(.WD_LIMIT(24'h00_0010)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_recover(stop_recover), .line_retrace_pulse(retrace),
    .on_primary_oscillator(on_primary), .conversion_result(result),
    .sync_in_line(in_line), .sync_in_frame(~in_line), .sync_gen_line(gen_line),
    .sync_gen_frame(~gen_line), .clamp_pulse_video(clamp_v), .clamp_pulse_aux(clamp_a),
    .osc_enable(osc_en), .core_fast_select(fast_sel), .watchdog_reset_pulse(wd_rst),
    .stop_pulse(stop_p), .sync_pin_output_enable(pin_oe), .sync_line_out(line_out),
    .sync_frame_out(frame_out), .sync_line_internal(line_int), .sync_frame_internal(frame_int),
    .std_config(std_cfg), .conversion_input(conv_in), .conversion_rate(conv_rate));
  always #5 pclk = ~pclk;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One transfer; the idle edge at the end avoids a double drive of psel
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [32:0] want);
    exp_q.push_back(want);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, 33'h0_0000_0000);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] want);
    apb(1'b0, a, 32'h0000_0000, want);
  endtask
  task automatic watch(input int n);
    clamp_at = -1;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      if (clamp_v === 1'b1 && clamp_at < 0) clamp_at = i;
    end
  endtask
  // Answer monitor at the access edge, plus the hang limit
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
      if (!pwrite) check("prdata", prdata, e[31:0]);
    end
  end
  // Watchdog and stop strobes and the 100-cycle aux clamp caught off the launching edge
  always @(negedge pclk) begin
    if (wd_rst === 1'b1) seen_wd = 1'b1;
    if (stop_p === 1'b1) seen_stop = 1'b1;
    if (clamp_a === 1'b1) seen_aux = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    result = rnd[3:0];
    seen_aux = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Bank 1 taken as selected for every access that follows
    rd(12'h000, 33'h0_0000_c000);
    rd(12'h004, 33'h0_0000_0000);
    rd(12'h008, 33'h0_0000_0000);
    rd(12'h00c, 33'h0_0000_0000);
    // Clamp on a primary-oscillator line, position kept in the legal range
    rnd = lfsr(rnd);
    d = {rnd[31:16], 2'b01, rnd[13:7], 7'h11 + {1'b0, rnd[5:0]}};
    wr(12'h000, d);
    rd(12'h000, {17'h0_0000, 2'b01, 7'h00, d[6:0]});
    on_primary <= 1'b1;
    retrace <= 1'b1;
    watch(800);
    // 82 ns per count on a 10 ns clock, plus synchroniser and divider latency
    clamp_lo = d[6:0] * 82 / 10;
    check("clamp delay", {31'h0, clamp_at >= clamp_lo && clamp_at <= clamp_lo + 8}, 1);
    check("aux clamp", {31'h0, seen_aux}, 0);
    retrace <= 1'b0;
    on_primary <= 1'b0;
    watch(4);
    retrace <= 1'b1;
    watch(800);
    check("clamp off primary", clamp_at, -1);
    // Watchdog: refused in slow mode, fires in fast, holds while slow
    seen_wd = 1'b0;
    wr(12'h004, 32'hffff_fffe);
    rd(12'h004, 33'h0_0000_0002);
    wr(12'h008, 32'h0000_0002);
    watch(60);
    check("kick refused", {31'h0, seen_wd}, 0);
    wr(12'h004, 32'h0000_0003);
    wr(12'h008, 32'h0000_0002);
    watch(60);
    check("watchdog fired", {31'h0, seen_wd}, 1);
    rd(12'h004, 33'h0_0000_0000);
    wr(12'h004, 32'h0000_0003);
    wr(12'h008, 32'h0000_0002);
    seen_wd = 1'b0;
    wr(12'h004, 32'h0000_0002);
    watch(60);
    check("watchdog held", {31'h0, seen_wd}, 0);
    wr(12'h004, 32'h0000_0003);
    watch(40);
    check("watchdog resumed", {31'h0, seen_wd}, 1);
    // Stop strobe, then stop-mode recovery
    seen_stop = 1'b0;
    wr(12'h008, 32'h0000_0000);
    watch(4);
    check("stop on zero", {31'h0, seen_stop}, 0);
    wr(12'h008, 32'h0000_0001);
    watch(4);
    check("stop on one", {31'h0, seen_stop}, 1);
    wr(12'h004, 32'h0000_0003);
    stop_recover <= 1'b1;
    @(posedge pclk);
    stop_recover <= 1'b0;
    rd(12'h004, 33'h0_0000_0000);
    // Standard register, internal then external sync
    rnd = lfsr(rnd);
    d = {rnd[31:14], 1'b1, rnd[12:1], 1'b0};
    gen_line <= 1'b1;
    in_line <= 1'b1;
    wr(12'h00c, d);
    rd(12'h00c, {19'h0_0000, d[13:0]});
    check("std cfg", {20'h0, std_cfg}, {20'h0, d[12:4], d[2:0]});
    check("pin oe", {31'h0, pin_oe}, 1);
    check("line out", {31'h0, line_out}, {31'h0, ~d[3]});
    check("line int", {31'h0, line_int}, 1);
    check("frame out", {31'h0, frame_out}, {31'h0, d[3]});
    check("frame int", {31'h0, frame_int}, 0);
    wr(12'h00c, d | 32'h0000_0001);
    repeat (3) @(posedge pclk);
    check("pin oe ext", {31'h0, pin_oe}, 0);
    check("line int ext", {31'h0, line_int}, {31'h0, ~d[1]});
    check("frame int ext", {31'h0, frame_int}, {31'h0, d[1]});
    // Every conversion mode, with four of the eight input codes (000, 101, 010, 111)
    for (int i = 0; i < 4; i++) begin
      wr(12'h010, {21'h0, i[0], 2'b00, i[1:0], i[1:0], 4'hf});
      @(posedge pclk);
      check("rate", {30'h0, conv_rate}, i);
      check("input", {29'h0, conv_in}, {29'h0, i[0], i[1:0]});
    end
    rd(12'h010, {22'h0, 1'b1, 2'b00, 4'hf, result});
    apb(1'b1, 12'h014, 32'hffff_ffff, 33'h1_0000_0000);
    apb(1'b0, 12'h014, 32'h0000_0000, 33'h1_0000_0000);
    final_report();
  end
endmodule // tb

//--- bench/tv_ctrl_bank1_asserts.sv
//////////////////////////////////////////////////////////////////////
module tv_ctrl_bank1_asserts #(
  parameter [23:0] WD_LIMIT = 24'h00_4000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        stop_recover,
  input wire logic        clamp_pulse_video,
  input wire logic        osc_enable,
  input wire logic        core_fast_select,
  input wire logic        stop_pulse,
  input wire logic        sync_pin_output_enable,
  input wire logic [11:0] std_config
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access decode; five aligned words are mapped
  wire acc    = psel && penable;
  wire mapped = (paddr <= 12'h010) && (paddr[1:0] == 2'b00);
  // Clamp length counter, since a repetition of 100 is too long to unroll
  reg  [7:0] clamp_len_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      clamp_len_reg <= 8'h00;
    else
      clamp_len_reg <= clamp_pulse_video ? clamp_len_reg + 8'h01 : 8'h00;
  end
  sequence speed_wr_s;
    acc && pwrite && (paddr == 12'h004);
  endsequence
  sequence stop_wr_s;
    acc && pwrite && (paddr == 12'h008) && pwdata[0];
  endsequence
  bad_addr_a: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  upper_zero_a: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  strobe_read_a: assert property (acc && !pwrite && paddr == 12'h008 |-> prdata == 32'h0)
    else $error("strobe word read not zero");
  speed_apply_a: assert property (speed_wr_s |-> ##2
    ({osc_enable, core_fast_select} == $past(pwdata[1:0], 2)))
    else $error("speed outputs differ from write");
  stop_strobe_a: assert property (stop_wr_s |-> ##[1:2] stop_pulse)
    else $error("stop pulse missing");
  recover_clear_a: assert property (stop_recover |-> ##2 !osc_enable && !core_fast_select)
    else $error("speed bits survive recovery");
  clamp_width_a: assert property ($fell(clamp_pulse_video) |-> clamp_len_reg == 8'd100)
    else $error("clamp width wrong");
  pin_dir_a: assert property (sync_pin_output_enable |-> !std_config[0])
    else $error("sync pins driven in external mode");
endmodule // tv_ctrl_bank1_asserts

bind tv_ctrl_bank1 tv_ctrl_bank1_asserts #(.WD_LIMIT(WD_LIMIT)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .stop_recover(stop_recover), .clamp_pulse_video(clamp_pulse_video),
  .osc_enable(osc_enable), .core_fast_select(core_fast_select), .stop_pulse(stop_pulse),
  .sync_pin_output_enable(sync_pin_output_enable), .std_config(std_config)
);

//--- design/tv_ctrl_bank1.v
`include "tv_ctrl_regs.vh"

module tv_ctrl_bank1 #(
  parameter [23:0] WD_LIMIT = `WD_TIMEOUT_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        stop_recover,
  input  wire        line_retrace_pulse,
  input  wire        on_primary_oscillator,
  input  wire [3:0]  conversion_result,
  input  wire        sync_in_line,
  input  wire        sync_in_frame,
  input  wire        sync_gen_line,
  input  wire        sync_gen_frame,
  output reg         clamp_pulse_video,
  output reg         clamp_pulse_aux,
  output reg         osc_enable,
  output reg         core_fast_select,
  output reg         watchdog_reset_pulse,
  output reg         stop_pulse,
  output reg         sync_pin_output_enable,
  output reg         sync_line_out,
  output reg         sync_frame_out,
  output reg         sync_line_internal,
  output reg         sync_frame_internal,
  output reg  [11:0] std_config,
  output reg  [2:0]  conversion_input,
  output reg  [1:0]  conversion_rate
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Software-visible state and bus answers
  reg  [15:0] clamp_reg;
  reg  [1:0]  speed_reg;
  reg  [15:0] std_reg;
  reg  [15:0] conv_reg;
  reg         pready_reg;
  reg         pslverr_reg;

  // Watchdog state
  reg         wd_enabled_reg;
  reg  [23:0] wd_count_reg;

  // Two-flop synchronisers and edge history for pin inputs
  reg         retr_m_reg;
  reg         retr_s_reg;
  reg         retr_d_reg;
  reg         prim_m_reg;
  reg         prim_s_reg;
  reg         sl_m_reg;
  reg         sl_s_reg;
  reg         sf_m_reg;
  reg         sf_s_reg;
  reg  [3:0]  res_m_reg;
  reg  [3:0]  res_s_reg;
  reg  [3:0]  res_d_reg;
  reg  [3:0]  res_held_reg;

  // Clamp timing
  reg         prim_at_sync_reg;
  reg  [7:0]  step_acc_reg;
  reg  [7:0]  delay_reg;
  reg         delay_run_reg;
  reg  [7:0]  width_reg;
  reg         width_run_reg;

  // Read path
  reg  [31:0] rdata_next;
  reg         addr_hit;

  wire        wr_en    = psel & penable & pwrite;
  wire [15:0] wd16     = pwdata[15:0];
  wire        sel_clamp = (paddr == `CLAMP_ADDR);
  wire        sel_speed = (paddr == `SPEED_ADDR);
  wire        sel_wd    = (paddr == `WDSTOP_ADDR);
  wire        sel_std   = (paddr == `STD_ADDR);
  wire        sel_conv  = (paddr == `CONV_ADDR);
  wire        fast_mode = speed_reg[`SPEED_OSC_BIT] & speed_reg[`SPEED_FAST_BIT];
  // Stop recovery or watchdog reset, which must drop the speed bits and watchdog; presetn does the same below
  wire        soft_reset = stop_recover | watchdog_reset_pulse;

  // Zero wait states; both answers come from flops armed in setup
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits come back as zero
  always @* begin
    addr_hit   = sel_clamp | sel_speed | sel_wd | sel_std | sel_conv;
    rdata_next = 32'h0000_0000;
    if (sel_clamp) begin
      rdata_next[15:0] = clamp_reg;
    end else if (sel_speed) begin
      rdata_next[1:0] = speed_reg;
    end else if (sel_std) begin
      rdata_next[15:0] = std_reg;
    end else if (sel_conv) begin
      rdata_next[15:0] = {conv_reg[15:4], res_held_reg};
    end
  end

  // Registered read data, captured during setup so it is valid in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rdata_next;
    end
  end

  // Ready and error stand only in the access cycle that follows setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel & ~penable;
      pslverr_reg <= psel & ~penable & ~addr_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_reg <= `CLAMP_RESET;
      std_reg   <= `STD_RESET;
      conv_reg  <= `CONV_RESET;
    end else if (wr_en) begin
      // Writes land on the access edge only
      if (sel_clamp) clamp_reg <= wd16 & `CLAMP_WMASK;
      if (sel_std)   std_reg   <= wd16 & `STD_WMASK;
      if (sel_conv)  conv_reg  <= wd16 & `CONV_WMASK;
    end
  end

  // Speed bits, cleared by every reset source
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_reg <= 2'b00;
    end else if (soft_reset) begin
      speed_reg <= 2'b00;
    end else if (wr_en & sel_speed) begin
      speed_reg <= wd16[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog and stop strobes; register itself stores nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_enabled_reg       <= 1'b0;
      wd_count_reg         <= 24'h00_0000;
      watchdog_reset_pulse <= 1'b0;
      stop_pulse           <= 1'b0;
    end else begin
      watchdog_reset_pulse <= 1'b0;
      stop_pulse           <= wr_en & sel_wd & wd16[`WD_STOP_BIT];
      if (soft_reset) begin
        wd_enabled_reg <= 1'b0;
        wd_count_reg   <= 24'h00_0000;
      end else if (wr_en & sel_wd & wd16[`WD_KICK_BIT] & fast_mode) begin
        // Restart ignored unless oscillators on and fast selected
        wd_enabled_reg <= 1'b1;
        wd_count_reg   <= 24'h00_0000;
      end else if (wd_enabled_reg & fast_mode) begin
        // Slow mode freezes the count rather than clearing it
        if (wd_count_reg == WD_LIMIT - 24'h00_0001) begin
          watchdog_reset_pulse <= 1'b1;
          wd_count_reg         <= 24'h00_0000;
        end else begin
          wd_count_reg <= wd_count_reg + 24'h00_0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pin-side inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retr_m_reg <= 1'b0;
      retr_s_reg <= 1'b0;
      retr_d_reg <= 1'b0;
      prim_m_reg <= 1'b0;
      prim_s_reg <= 1'b0;
      sl_m_reg   <= 1'b0;
      sl_s_reg   <= 1'b0;
      sf_m_reg   <= 1'b0;
      sf_s_reg   <= 1'b0;
      res_m_reg  <= 4'h0;
      res_s_reg  <= 4'h0;
      res_d_reg  <= 4'h0;
    end else begin
      retr_m_reg <= line_retrace_pulse;
      retr_s_reg <= retr_m_reg;
      retr_d_reg <= retr_s_reg;
      prim_m_reg <= on_primary_oscillator;
      prim_s_reg <= prim_m_reg;
      sl_m_reg   <= sync_in_line;
      sl_s_reg   <= sl_m_reg;
      sf_m_reg   <= sync_in_frame;
      sf_s_reg   <= sf_m_reg;
      res_m_reg  <= conversion_result;
      res_s_reg  <= res_m_reg;
      res_d_reg  <= res_s_reg;
    end
  end

  // Result bits may change at different moments; keep a word once two samples agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_held_reg <= 4'h0;
    end else if (res_s_reg == res_d_reg) begin
      res_held_reg <= res_s_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clamp timing: delay from retrace edge, then fixed width
  wire retrace_rise = retr_s_reg & ~retr_d_reg;
  // Delay counted in 82 ns steps of the position field
  wire [7:0] pos_val = {1'b0, clamp_reg[6:0]};
  wire [7:0] width_cyc = `CLAMP_WIDTH_CYC;
  // 82 ns steps from a 10 ns clock: a fractional divider gives one-cycle ticks that
  // average one per step, so the start may land up to one clock late
  wire [7:0] step_sum  = step_acc_reg + `CLK_PERIOD_NS;
  wire       step_tick = (step_sum >= `POS_STEP_NS);

  // Step divider restarts at each retrace edge so every line counts alike
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_acc_reg <= 8'h00;
    end else if (retrace_rise) begin
      step_acc_reg <= 8'h00;
    end else if (step_tick) begin
      step_acc_reg <= step_sum - `POS_STEP_NS;
    end else begin
      step_acc_reg <= step_sum;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_at_sync_reg  <= 1'b0;
      delay_reg         <= 8'h00;
      delay_run_reg     <= 1'b0;
      width_reg         <= 8'h00;
      width_run_reg     <= 1'b0;
      clamp_pulse_video <= 1'b0;
      clamp_pulse_aux   <= 1'b0;
    end else begin
      if (retrace_rise) begin
        // Oscillator state latched at line sync gates this line's clamp
        prim_at_sync_reg <= prim_s_reg;
        delay_reg        <= pos_val;
        delay_run_reg    <= 1'b1;
        width_run_reg    <= 1'b0;
      end else if (delay_run_reg) begin
        if (delay_reg == 8'h00) begin
          delay_run_reg <= 1'b0;
          width_run_reg <= 1'b1;
          width_reg     <= width_cyc - 8'h01;
        end else if (step_tick) begin
          delay_reg <= delay_reg - 8'h01;
        end
      end else if (width_run_reg) begin
        if (width_reg == 8'h00) begin
          width_run_reg <= 1'b0;
        end else begin
          width_reg <= width_reg - 8'h01;
        end
      end
      clamp_pulse_video <= width_run_reg & prim_at_sync_reg
                           & ~clamp_reg[`CLAMP_DIS1_BIT];
      clamp_pulse_aux   <= width_run_reg & prim_at_sync_reg
                           & ~clamp_reg[`CLAMP_DIS2_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs driven from the configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_pin_output_enable <= 1'b0;
      sync_line_out          <= 1'b0;
      sync_frame_out         <= 1'b0;
      sync_line_internal     <= 1'b0;
      sync_frame_internal    <= 1'b0;
      std_config             <= 12'h000;
    end else begin
      // Pins drive only when unmasked and internal sync is chosen
      sync_pin_output_enable <= std_reg[`STD_PINOE_BIT]
                                & ~std_reg[`STD_EXT_BIT];
      // Pad polarity only; internal copies keep their sense
      sync_line_out  <= sync_gen_line  ^ std_reg[`STD_OUTPOL_BIT];
      sync_frame_out <= sync_gen_frame ^ std_reg[`STD_OUTPOL_BIT];
      if (std_reg[`STD_EXT_BIT]) begin
        // External sync: bit 1 gives expected incoming polarity
        sync_line_internal  <= sl_s_reg ^ std_reg[`STD_POL_BIT];
        sync_frame_internal <= sf_s_reg ^ std_reg[`STD_POL_BIT];
      end else begin
        sync_line_internal  <= sync_gen_line;
        sync_frame_internal <= sync_gen_frame;
      end
      // Bits c,b,a,9,8,7,6,5,4,2,1,0 passed to the video logic
      std_config <= {std_reg[12:4], std_reg[2:0]};
    end
  end

  // Speed outputs trail the register by one clock; the clock switch sits outside
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_enable       <= 1'b0;
      core_fast_select <= 1'b0;
    end else begin
      osc_enable       <= speed_reg[`SPEED_OSC_BIT];
      core_fast_select <= speed_reg[`SPEED_FAST_BIT];
    end
  end

  // Converter selection to the analog side
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_input <= 3'b000;
      conversion_rate  <= 2'b00;
    end else begin
      conversion_input <= {conv_reg[`CONV_GROUP_BIT], conv_reg[5:4]};
      conversion_rate  <= conv_reg[7:6];
    end
  end

endmodule // tv_ctrl_bank1

//--- design/tv_ctrl_regs.vh
// What this block does
// - Two clamp disable bits, one per video input; 1 inhibits; both set at reset.
// - Clamp pulse only when enabled and core was on primary oscillator before line sync.
// - Clamp pulse width fixed at one microsecond, no register adjusts it.
// - Seven bit position sets clamp delay from retrace edge, 82 ns per count.
// - Every reset clears both speed bits, core runs from slow reference.
// - Watchdog/stop strobes: write 1 acts, write 0 nothing, always read zero.
// - Watchdog off after resets; restart accepted only with oscillators on and fast.
// - Watchdog counter holds in slow mode and resumes in fast mode.
// - Bits a, 9, 8, 6 route composite sync, colour, I2C pair, line blank.
// - Bit 7 selects glyph ROM page at hex 1000 or hex 0000.
// - Bit 5 enables overlay; reset clears it and makes sync pins inputs.
// - Bit 4 colour polarity; bit 3 inverts only pad sync outputs.
// - Bit 1 picks line standard internally, or expected input sync polarity externally.
// - Bit 0 picks external sync with pins as inputs, else internal, pins driven only when bit 13 is set.
// - Converter bits 7:6 conversion mode; bits 3:0 read result, writes ignored.
`ifndef TV_CTRL_REGS_VH
`define TV_CTRL_REGS_VH
// Register indices and byte addresses (byte address = 4 x index)
`define CLAMP_IDX        4'h0
`define SPEED_IDX        4'h1
`define WDSTOP_IDX       4'h2
`define STD_IDX          4'h3
`define CONV_IDX         4'h4
`define CLAMP_ADDR       12'h000
`define SPEED_ADDR       12'h004
`define WDSTOP_ADDR      12'h008
`define STD_ADDR         12'h00c
`define CONV_ADDR        12'h010
// Field positions
`define CLAMP_DIS1_BIT   15
`define CLAMP_DIS2_BIT   14
`define SPEED_OSC_BIT    1
`define SPEED_FAST_BIT   0
`define WD_KICK_BIT      1
`define WD_STOP_BIT      0
`define STD_EXT_BIT      0
`define STD_POL_BIT      1
`define STD_OUTPOL_BIT   3
`define STD_PINOE_BIT    13
`define CONV_GROUP_BIT   10
// Reset values and write masks
`define CLAMP_RESET      16'hc000
`define CLAMP_WMASK      16'hc07f
`define STD_RESET        16'h0000
`define STD_WMASK        16'h3fff
`define CONV_RESET       16'h0000
`define CONV_WMASK       16'h04f0
// Timing: clamp width 1 us at 10 ns core period; position step 82 ns
`define CLK_PERIOD_NS    8'h0a
`define CLAMP_WIDTH_NS   16'h03e8
`define CLAMP_WIDTH_CYC  8'h64
`define POS_STEP_NS      8'h52
`define WD_TIMEOUT_CYC   24'h00_4000
`endif
